/* File: wake_guard_pkg.sv */
// Purpose: shared constants and types for the wake and write guard block
// Assumes: SPI mode 0, MSB first
// Notes: command codes and signature are parameters of the top module
package wake_guard_pkg;
   localparam int CMD_BITS = 8;
   localparam int ADDR_BITS = 16;
   localparam int SIG_BITS = 8;
   localparam logic [4:0] CMD_LAST = 5'h07;
   localparam logic [4:0] ADDR_LAST = 5'h17;
   localparam logic [4:0] BYTE_LAST = 5'h1f;
   // Delays in ns
   localparam int WAKE_DELAY_NS = 1000;
   localparam int SLEEP_DELAY_NS = 1000;
   localparam int CLK_NS = 25;
   localparam int WAKE_CYCLES = (WAKE_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLEEP_CYCLES = (SLEEP_DELAY_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      PWR_STANDBY = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_WAKING = 2'b10
   } power_state_t;
   // Frame end summary passed from link to core domain
   typedef struct packed {
      logic [4:0] bitCount;
      logic [7:0] opcode;
      logic isWake;
   } frame_info_t;
endpackage

/* File: wake_and_write_guard.sv */
// How it works
// - In sleep every command except the wake-and-signature command is ignored.
// - Outside sleep the wake command reads the signature unless a write is busy.
// - After the last dummy bit the eight-bit signature shifts out on serial output.
// - After chip select rises the device enters standby once the wake delay passes.
// - Further clocks keep repeating the signature until chip select rises.
// - Raising chip select right after the wake code still leaves sleep.
// - The write unlock latch is cleared at reset.
// - Only the write unlock command sets the write unlock latch.
// - A finished byte, page or status write clears the write unlock latch.
// - A write starts only when chip select rises after 24 bits, or 24 plus a multiple of eight bits.
// - Array accesses during a busy internal write are ignored.
// - After reset the device is in standby with serial output not driven.
// - Sleep is entered only if chip select rises right after the eighth code bit.
// - Reset cancels sleep and returns to standby.
////////////////////////////////////////////////////////////////////////////////
// Purpose: sleep release, signature readout and write unlock guard
// Assumes: SPI mode 0; csN high frames end; writeDone pulses from write engine
// Notes: link logic on sck, power and latch logic on clk
`timescale 1ns/1ps
module wake_and_write_guard
   import wake_guard_pkg::*;
#(
   parameter logic [7:0] WAKE_CMD = 8'hab,  // Arbitrary value
   parameter logic [7:0] SLEEP_CMD = 8'hb9,  // Arbitrary value
   parameter logic [7:0] UNLOCK_CMD = 8'h06,  // Arbitrary value
   parameter logic [7:0] SIGNATURE = 8'h5a,  // Arbitrary value
   parameter logic [4:0] WRITE_BITS = 5'h18  // Bits of a valid write frame
) (
   // Core clock and reset
   input wire logic clk,
   input wire logic reset,
   // Serial link
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   output logic so,
   output logic soEn,
   // Write engine side
   input wire logic writeOpcode,
   input wire logic writeDone,
   output logic writeStart,
   output logic writeUnlockLatch,
   output logic internalWriteBusy,
   output logic asleep
);
   ////////////////////////////////////////////////////////////////////////////
   // Link domain: shift register and counter are kept at csN; it clears the frame flag, gate and outputs and sets the signature index to 7
   logic [4:0] bitCount_reg;
   logic [7:0] shift_reg;
   logic [7:0] opcode_reg;
   logic [2:0] sigIdx_reg;
   logic linkGate_reg;
   logic frameOpen_reg;
   // Count restarts at the first clock of a frame; values stand after csN rises
   wire [4:0] countBase = frameOpen_reg ? bitCount_reg : 5'h00;
   wire [7:0] shiftNext = {shift_reg[6:0], si};
   wire atCodeEnd = (countBase == CMD_LAST);
   wire isWakeCode = (opcode_reg == WAKE_CMD);
   wire inSig = (bitCount_reg > ADDR_LAST);

   // Bits count up; address bits after the code are ignored
   always_ff @(posedge sck or posedge csN) begin
      if (csN) frameOpen_reg <= 1'b0;
      else frameOpen_reg <= 1'b1;
   end
   // Frame summary kept after deselect so the core can judge it
   always_ff @(posedge sck) begin
      shift_reg <= shiftNext;
      if (countBase != BYTE_LAST) bitCount_reg <= countBase + 5'h01;
      else bitCount_reg <= ADDR_LAST + 5'h01;
      if (atCodeEnd) opcode_reg <= shiftNext;
   end

   // Gate: wake command allowed unless busy while awake (sampled core levels)
   logic busySync1_reg, busySync2_reg, sleepSync1_reg, sleepSync2_reg;
   always_ff @(posedge sck) begin
      busySync1_reg <= internalWriteBusy;
      busySync2_reg <= busySync1_reg;
      sleepSync1_reg <= asleep;
      sleepSync2_reg <= sleepSync1_reg;
   end
   wire sigAllowed = isWakeCode && !(busySync2_reg && !sleepSync2_reg);

   // Signature out on falling edge, MSB first
   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         sigIdx_reg <= 3'h7;
         linkGate_reg <= 1'b0;
      end else begin
         linkGate_reg <= inSig && sigAllowed;
         if (inSig && sigAllowed) sigIdx_reg <= sigIdx_reg - 3'h1;
      end
   end
   // Output registers from falling edge
   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         so <= 1'b0;
         soEn <= 1'b0;
      end else begin
         so <= SIGNATURE[sigIdx_reg];
         soEn <= inSig && sigAllowed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core domain: catch frame info at csN rise via synchronised csN
   logic cs1_reg, cs2_reg, cs3_reg;
   frame_info_t frame_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         cs1_reg <= 1'b1;
         cs2_reg <= 1'b1;
         cs3_reg <= 1'b1;
      end else begin
         cs1_reg <= csN;
         cs2_reg <= cs1_reg;
         cs3_reg <= cs2_reg;
      end
   end
   wire frameEnd = cs2_reg && !cs3_reg;
   // Link registers hold steady after csN rise until next frame, then stable
   frame_info_t liveInfo;
   assign liveInfo = '{bitCount: bitCount_reg, opcode: opcode_reg, isWake: isWakeCode};
   always_ff @(posedge clk) begin
      if (reset) frame_reg <= '0;
      else if (cs1_reg && !cs2_reg) frame_reg <= liveInfo; // Quiet link, safe capture
      else if (cs2_reg && cs3_reg) frame_reg <= '0;
   end

   wire exactCode = (frame_reg.bitCount == CMD_LAST + 5'h01);
   wire wakeFrame = frame_reg.isWake && (frame_reg.bitCount > CMD_LAST);
   wire sleepFrame = exactCode && (frame_reg.opcode == SLEEP_CMD);
   wire unlockFrame = exactCode && (frame_reg.opcode == UNLOCK_CMD);
   wire writeFrame = writeOpcode && (frame_reg.bitCount == WRITE_BITS);

   power_state_t pwr_reg, pwr_next;
   logic [15:0] delay_reg;
   logic busy_reg;
   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         PWR_STANDBY: if (frameEnd && sleepFrame && !busy_reg) pwr_next = PWR_SLEEP;
         PWR_SLEEP: if (frameEnd && wakeFrame) pwr_next = PWR_WAKING;
         PWR_WAKING: if (delay_reg == 16'h0000) pwr_next = PWR_STANDBY;
         default: pwr_next = PWR_STANDBY;
      endcase
   end
   wire awake = (pwr_reg == PWR_STANDBY);
   wire acceptCmd = frameEnd && awake && !busy_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         pwr_reg <= PWR_STANDBY;
         delay_reg <= 16'h0000;
         busy_reg <= 1'b0;
         writeUnlockLatch <= 1'b0;
         writeStart <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         if (pwr_reg == PWR_SLEEP) delay_reg <= 16'(WAKE_CYCLES);
         else if (delay_reg != 16'h0000) delay_reg <= delay_reg - 16'h0001;
         writeStart <= acceptCmd && writeFrame && writeUnlockLatch;
         if (acceptCmd && writeFrame && writeUnlockLatch) busy_reg <= 1'b1;
         else if (writeDone) busy_reg <= 1'b0;
         if (writeDone) writeUnlockLatch <= 1'b0;
         else if (acceptCmd && unlockFrame) writeUnlockLatch <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         internalWriteBusy <= 1'b0;
         asleep <= 1'b0;
      end else begin
         internalWriteBusy <= busy_reg;
         asleep <= (pwr_next != PWR_STANDBY);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_reset_latch_clear: assert property (@(posedge clk)
      reset |=> !writeUnlockLatch) else $error("latch set after reset");
   a_latch_set_cause: assert property (@(posedge clk) disable iff (reset)
      $rose(writeUnlockLatch) |-> $past(acceptCmd && unlockFrame))
      else $error("latch set without unlock");
   a_done_clears_latch: assert property (@(posedge clk) disable iff (reset)
      writeDone |=> !writeUnlockLatch) else $error("latch kept after write");
   a_start_needs_count: assert property (@(posedge clk) disable iff (reset)
      writeStart |-> $past(writeFrame && writeUnlockLatch && awake))
      else $error("write start bad frame");
   a_busy_no_start: assert property (@(posedge clk) disable iff (reset)
      busy_reg |=> !writeStart) else $error("start while busy");
   a_sleep_ignores: assert property (@(posedge clk) disable iff (reset)
      (pwr_reg == PWR_SLEEP && frameEnd && !wakeFrame) |=> pwr_reg == PWR_SLEEP)
      else $error("sleep left by other command");
   a_wake_release: assert property (@(posedge clk) disable iff (reset)
      (pwr_reg == PWR_SLEEP && frameEnd && wakeFrame) |=> pwr_reg == PWR_WAKING)
      else $error("wake frame ignored");
   a_wake_bounded: assert property (@(posedge clk) disable iff (reset)
      pwr_reg == PWR_WAKING |-> ##[0:45] pwr_reg == PWR_STANDBY)
      else $error("wake delay too long");
   a_sleep_exact: assert property (@(posedge clk) disable iff (reset)
      (awake && $past(awake) && pwr_next == PWR_SLEEP) |-> sleepFrame && frameEnd)
      else $error("sleep without exact frame");
   a_so_quiet_idle: assert property (@(posedge clk) disable iff (reset) csN |-> !soEn)
      else $error("so driven while deselected");
   c_sleep_entry: cover property (@(posedge clk) pwr_reg == PWR_SLEEP);
   c_wake_done: cover property (@(posedge clk) $fell(pwr_reg == PWR_WAKING));
   c_write_start: cover property (@(posedge clk) writeStart);
   c_signature_out: cover property (@(posedge sck) soEn);
endmodule

/* File: spi_host_model.sv */
// Purpose: SPI host model that sends frames to the guard block
// Assumes: mode 0, MSB first, sck stands low outside frames
// Notes: si shows the inverse of its last bit once released
`timescale 1ns/1ps
module spi_host_model (
   // Serial link
   output logic sck,
   output logic csN,
   output logic si
);
   // Idle link
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Send n bits from the top of bits, then deselect
   task automatic frame(input logic [39:0] bits, input int n);
      int i;
      #3;
      csN = 1'b0;
      for (i = 0; i < n; i++) begin
         si = bits[39 - i];
         #15 sck = 1'b1;
         #15 sck = 1'b0;
      end
      #15 csN = 1'b1;
      si = ~si;
   endtask
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the wake and write guard
// Assumes: host model drives the link, bench drives the write engine side
// Notes: signature bits are noted in a queue and checked at sck rise
`timescale 1ns/1ps
module testbench;
   import wake_guard_pkg::*;
   localparam logic [7:0] WAKE = 8'hab;
   localparam logic [7:0] SLEEP = 8'hb9;
   localparam logic [7:0] UNLOCK = 8'h06;
   localparam logic [7:0] SIG = 8'h5a;
   logic clk, reset, sck, csN, si, so, soEn, writeOpcode, writeDone;
   logic writeStart, writeUnlockLatch, internalWriteBusy, asleep;
   logic expQ[$];
   int fails = 0;
   int comparisons = 0;
   int starts = 0;
   logic [15:0] dummy;
   spi_host_model i_host (.sck(sck), .csN(csN), .si(si));
   wake_and_write_guard #(.WAKE_CMD(WAKE), .SLEEP_CMD(SLEEP), .UNLOCK_CMD(UNLOCK),
      .SIGNATURE(SIG), .WRITE_BITS(5'h18)) i_dut (.clk(clk), .reset(reset), .sck(sck),
      .csN(csN), .si(si), .so(so), .soEn(soEn), .writeOpcode(writeOpcode),
      .writeDone(writeDone), .writeStart(writeStart), .writeUnlockLatch(writeUnlockLatch),
      .internalWriteBusy(internalWriteBusy), .asleep(asleep));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and helpers
   always #12.5 clk = ~clk;
   initial begin
      #2000000;
      fails++;
      conclude();
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic conclude();
      if (fails == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Signature monitor and start counter
   always @(posedge sck) begin
      if (soEn === 1'b1) begin
         if (expQ.size() == 0) check("soEn", 8'h01, 8'h00);
         else check("so", {7'h0, so}, {7'h0, expQ.pop_front()});
      end
   end
   always @(posedge clk) if (writeStart === 1'b1) starts++;
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      writeOpcode = 1'b0;
      writeDone = 1'b0;
      void'($urandom(32'h6227));
      idle(6);
      reset = 1'b0;
      idle(4);
      check("latch", {7'h0, writeUnlockLatch}, 8'h00);
      check("asleep", {7'h0, asleep}, 8'h00);
      check("soEn", {7'h0, soEn}, 8'h00);
      dummy = 16'($urandom);
      for (int b = 15; b >= 0; b--) expQ.push_back(SIG[b % 8]);
      i_host.frame({WAKE, dummy, 16'h0}, 40);
      idle(10);
      check("sig left", 8'(expQ.size()), 8'h00);
      i_host.frame({UNLOCK, 32'h0}, 8);
      idle(10);
      check("latch", {7'h0, writeUnlockLatch}, 8'h01);
      writeOpcode = 1'b1;
      i_host.frame({8'h02, dummy, 16'h0}, 23);
      idle(10);
      check("starts", 8'(starts), 8'h00);
      i_host.frame({8'h02, dummy, 16'h0}, 24);
      idle(10);
      check("starts", 8'(starts), 8'h01);
      check("busy", {7'h0, internalWriteBusy}, 8'h01);
      writeOpcode = 1'b0;
      i_host.frame({WAKE, dummy, 16'h0}, 40);
      idle(10);
      writeDone = 1'b1;
      idle(1);
      writeDone = 1'b0;
      idle(4);
      check("latch", {7'h0, writeUnlockLatch}, 8'h00);
      i_host.frame({SLEEP, 32'h0}, 9);
      idle(60);
      check("asleep", {7'h0, asleep}, 8'h00);
      i_host.frame({SLEEP, 32'h0}, 8);
      idle(60);
      check("asleep", {7'h0, asleep}, 8'h01);
      i_host.frame({UNLOCK, 32'h0}, 8);
      idle(10);
      check("latch", {7'h0, writeUnlockLatch}, 8'h00);
      i_host.frame({WAKE, 32'h0}, 8);
      idle(10);
      check("asleep", {7'h0, asleep}, 8'h01);
      idle(50);
      check("asleep", {7'h0, asleep}, 8'h00);
      i_host.frame({SLEEP, 32'h0}, 8);
      idle(60);
      reset = 1'b1;
      idle(2);
      reset = 1'b0;
      idle(4);
      check("asleep", {7'h0, asleep}, 8'h00);
      conclude();
   end
endmodule
